// File: src/sts_pkg.sv
// constants shared by the smbus thermometer target logic
package sts_pkg;
  localparam int unsigned CLK_MHZ = 250;
  // scl low timeout, longest time, rounded down
  localparam int unsigned SCL_LOW_TIMEOUT_US = 27000;
  localparam int unsigned SCL_LOW_TIMEOUT_CYC = SCL_LOW_TIMEOUT_US * CLK_MHZ;
  // scl high timeout, longest time, rounded down
  localparam int unsigned SCL_HIGH_TIMEOUT_US = 45;
  localparam int unsigned SCL_HIGH_TIMEOUT_CYC = SCL_HIGH_TIMEOUT_US * CLK_MHZ;
  // nonvolatile commit time, least time, rounded up
  localparam int unsigned NV_PROG_US = 5000;
  localparam int unsigned NV_PROG_CYC = NV_PROG_US * CLK_MHZ;
  // sda change hold-off after scl falls, least time, rounded up
  localparam int unsigned SDA_HOLD_NS = 300;
  localparam int unsigned SDA_HOLD_CYC = (SDA_HOLD_NS * CLK_MHZ + 999) / 1000;
  // ack timing limits, met by the hold-off above plus sync latency
  localparam int unsigned TARGET_ACK_ASSERT_DELAY_NS = 2500;
  localparam int unsigned TARGET_ACK_RELEASE_DELAY_NS = 1500;
  localparam int unsigned HOST_ACK_RELEASE_DELAY_NS = 1500;
  localparam int unsigned HOST_ACK_RETAKE_DELAY_NS = 1500;

  localparam logic [7:0] CMD_AMBIENT = 8'h06;
  localparam logic [7:0] CMD_EMISSIVITY = 8'h24;
  localparam logic [7:0] CMD_TARGET_ADDR = 8'h2E;
  localparam logic [6:0] GENERAL_ADDR = 7'h00;

  localparam logic [15:0] EMISSIVITY_RESET = 16'hF850;
  localparam logic [15:0] TARGET_ADDR_RESET = 16'h003A;
  localparam logic [15:0] AMBIENT_MIN = 16'h2DE4;
  localparam logic [15:0] AMBIENT_MAX = 16'h4DC4;
  localparam logic [15:0] READING_MAX = 16'h7FFF;
  localparam logic [15:0] UNKNOWN_WORD = 16'h8000;
  localparam int unsigned ERROR_FLAG_BIT = 15;

  localparam logic [7:0] PEC_POLY = 8'h07;
  localparam logic [7:0] PEC_INIT = 8'h00;

  typedef enum logic [2:0] {
    ST_IDLE = 3'b000,
    ST_RX = 3'b001,
    ST_RXACK = 3'b010,
    ST_TX = 3'b011,
    ST_TXACK = 3'b100,
    ST_IGNORE = 3'b101
  } sts_state_type;
endpackage

// File: src/sts_pec_if.sv
// link between the protocol engine and its packet error code calculator
`timescale 1ns/1ps
`default_nettype none
interface sts_pec_if;
  logic clear;
  logic shift;
  logic bitIn;
  logic [7:0] crc;
  modport engine (output clear, output shift, output bitIn, input crc);
  modport calc (input clear, input shift, input bitIn, output crc);
endinterface
`default_nettype wire

// File: src/sts_pec_crc.sv
// bit-serial crc-8 for the packet error code
`timescale 1ns/1ps
`default_nettype none
module sts_pec_crc
  import sts_pkg::*;
(
  input wire logic sys_clk,
  input wire logic reset,
  sts_pec_if.calc pec
);
  logic [7:0] crc_q;
  logic feedback;

  assign feedback = crc_q[7] ^ pec.bitIn;
  assign pec.crc = crc_q;

  // polynomial x8+x2+x+1, msb first
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      crc_q <= PEC_INIT;
    end else if (pec.clear) begin
      crc_q <= PEC_INIT;
    end else if (pec.shift) begin
      crc_q <= {crc_q[6:0], 1'b0} ^ (feedback ? PEC_POLY : 8'h00);
    end
  end
endmodule
`default_nettype wire

// File: src/sts_target.sv
// smbus target of the thermometer: word reads, word writes, nv cells, timeouts
//
// Behaviour
// - ambient in 0.02 K steps, at most 0x7FFF
// - ambient reading clamped to 0x2DE4..0x4DC4
// - emissivity cell defaults to 0xF850
// - host may program emissivity 0.1 to 1.0
// - all-zero data word erases the cell
// - commit takes 5 ms; host waits
// - command 0x2E selects target address cell
// - command 0x24 selects emissivity, low first
// - scl low too long resets the engine
// - scl high too long resets to idle
// - ack driven after 8th fall, released after 9th
// - release for host ack, retake after it
// - sda changes only while scl low, except the release on an scl high timeout
// - pec is crc-8 over all bytes
// - temperature word msb flags an error
// - target address 0x3A out of reset
`timescale 1ns/1ps
`default_nettype none
module sts_target
  import sts_pkg::*;
#(
  parameter int unsigned LOW_TIMEOUT_CYCLES = SCL_LOW_TIMEOUT_CYC,
  parameter int unsigned HIGH_TIMEOUT_CYCLES = SCL_HIGH_TIMEOUT_CYC,
  parameter int unsigned PROG_CYCLES = NV_PROG_CYC
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  output logic sdaOut,
  output logic sdaOe,
  input wire logic [15:0] dieTemperatureReading,
  input wire logic sensorError,
  output logic [15:0] emissivityCoefficient,
  output logic [15:0] busTargetAddress,
  output logic nvBusy
);
  sts_pec_if pec ();

  sts_pec_crc u_pec (
    .sys_clk(sys_clk),
    .reset(reset),
    .pec(pec)
  );

  logic sclMeta_q, sclSync_q, sclPrev_q;
  logic sdaMeta_q, sdaSync_q, sdaPrev_q;
  logic sclRise, sclFall, startSeen, stopSeen, timeout;
  sts_state_type state_q;
  logic [3:0] bitCnt_q;
  logic [7:0] shift_q;
  logic [2:0] byteIdx_q;
  logic addrPhase_q, readMode_q;
  logic [7:0] cmd_q, dataLo_q, dataHi_q;
  logic [23:0] stableCnt_q;
  logic [23:0] progCnt_q;
  logic [7:0] holdCnt_q;
  logic [7:0] pendCmd_q;
  logic [15:0] pendData_q;
  logic [15:0] emis_q, addrCell_q;
  logic [15:0] ambient, readWord;
  logic addrMatch, byteEnd, writeValid, sdaTarget;

  // two flops on each pin before any logic looks at it
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      sclMeta_q <= 1'b1;
      sclSync_q <= 1'b1;
      sclPrev_q <= 1'b1;
      sdaMeta_q <= 1'b1;
      sdaSync_q <= 1'b1;
      sdaPrev_q <= 1'b1;
    end else if (clkEn) begin
      sclMeta_q <= sclIn;
      sclSync_q <= sclMeta_q;
      sclPrev_q <= sclSync_q;
      sdaMeta_q <= sdaIn;
      sdaSync_q <= sdaMeta_q;
      sdaPrev_q <= sdaSync_q;
    end
  end

  assign sclRise = sclSync_q & ~sclPrev_q;
  assign sclFall = ~sclSync_q & sclPrev_q;
  assign startSeen = sclSync_q & sclPrev_q & sdaPrev_q & ~sdaSync_q;
  assign stopSeen = sclSync_q & sclPrev_q & ~sdaPrev_q & sdaSync_q;

  // bus-stuck timers, measured only inside a transaction
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      stableCnt_q <= '0;
    end else if (clkEn) begin
      if (state_q == ST_IDLE || sclRise || sclFall) begin
        stableCnt_q <= '0;
      end else if (stableCnt_q != '1) begin
        stableCnt_q <= stableCnt_q + 24'h000001;
      end
    end
  end

  assign timeout = (state_q != ST_IDLE) &&
                   (sclSync_q ? (stableCnt_q >= 24'(HIGH_TIMEOUT_CYCLES))
                              : (stableCnt_q >= 24'(LOW_TIMEOUT_CYCLES)));

  // 0x3A out of reset; general address answered whatever the cell holds, but not during a commit
  assign addrMatch = (shift_q[7:1] == addrCell_q[6:0]) || (shift_q[7:1] == GENERAL_ADDR);
  assign byteEnd = sclFall && (bitCnt_q == 4'h8);

  // clamp keeps the value below 0x7FFF; bit 15 then carries sensorError
  always_comb begin
    ambient = dieTemperatureReading;
    if (ambient < AMBIENT_MIN) begin
      ambient = AMBIENT_MIN;
    end else if (ambient > AMBIENT_MAX) begin
      ambient = AMBIENT_MAX;
    end
    ambient[ERROR_FLAG_BIT] = sensorError;
  end

  always_comb begin
    case (cmd_q)
      CMD_AMBIENT: readWord = ambient;
      CMD_EMISSIVITY: readWord = emis_q;
      CMD_TARGET_ADDR: readWord = addrCell_q;
      default: readWord = UNKNOWN_WORD;
    endcase
  end

  // protocol engine
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      state_q <= ST_IDLE;
      bitCnt_q <= '0;
      shift_q <= '0;
      byteIdx_q <= '0;
      addrPhase_q <= 1'b0;
      readMode_q <= 1'b0;
      cmd_q <= '0;
      dataLo_q <= '0;
      dataHi_q <= '0;
    end else if (clkEn) begin
      if (timeout || stopSeen) begin
        state_q <= ST_IDLE;
      end else if (startSeen) begin
        state_q <= ST_RX;
        bitCnt_q <= '0;
        byteIdx_q <= '0;
        addrPhase_q <= 1'b1;
        readMode_q <= 1'b0;
      end else begin
        case (state_q)
          ST_RX: begin
            if (sclRise) begin
              shift_q <= {shift_q[6:0], sdaSync_q};
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (byteEnd) begin
              bitCnt_q <= '0;
              if (addrPhase_q) begin
                addrPhase_q <= 1'b0;
                readMode_q <= shift_q[0];
                // busy commit refuses new transactions
                state_q <= (addrMatch && !nvBusy) ? ST_RXACK : ST_IGNORE;
              end else if (byteIdx_q < 3'h4) begin
                byteIdx_q <= byteIdx_q + 3'h1;
                state_q <= ST_RXACK;
                case (byteIdx_q)
                  3'h0: cmd_q <= shift_q;
                  3'h1: dataLo_q <= shift_q;
                  3'h2: dataHi_q <= shift_q;
                  default: ;
                endcase
              end else begin
                state_q <= ST_IGNORE;
              end
            end
          end
          ST_RXACK: begin
            if (sclFall) begin
              if (readMode_q) begin
                shift_q <= readWord[7:0];
                byteIdx_q <= '0;
                state_q <= ST_TX;
              end else begin
                state_q <= ST_RX;
              end
            end
          end
          ST_TX: begin
            if (sclRise) begin
              bitCnt_q <= bitCnt_q + 4'h1;
            end else if (byteEnd) begin
              bitCnt_q <= '0;
              state_q <= ST_TXACK;
            end else if (sclFall) begin
              shift_q <= {shift_q[6:0], 1'b0};
            end
          end
          ST_TXACK: begin
            if (sclRise && sdaSync_q) begin
              state_q <= ST_IGNORE;
            end else if (sclFall) begin
              byteIdx_q <= byteIdx_q + 3'h1;
              if (byteIdx_q == 3'h0) begin
                shift_q <= readWord[15:8];
                state_q <= ST_TX;
              end else if (byteIdx_q == 3'h1) begin
                shift_q <= pec.crc;
                state_q <= ST_TX;
              end else begin
                state_q <= ST_IGNORE;
              end
            end
          end
          ST_IGNORE: ;
          default: state_q <= ST_IDLE;
        endcase
      end
    end
  end

  // pec shifts on the fall that closes a data bit, so the scl rise ahead of
  // a repeated start or a stop never reaches the crc
  assign pec.clear = clkEn && startSeen && (state_q == ST_IDLE);
  assign pec.shift = clkEn && sclFall && (bitCnt_q != 4'h0) && !startSeen && !stopSeen &&
                     !timeout && (state_q == ST_RX || state_q == ST_TX);
  assign pec.bitIn = sdaSync_q;

  // after the pec byte the running crc is zero only if it matched
  assign writeValid = (state_q == ST_RX) && !readMode_q && !addrPhase_q &&
                      (byteIdx_q == 3'h4) && (bitCnt_q <= 4'h1) && (pec.crc == 8'h00) &&
                      (cmd_q == CMD_EMISSIVITY || cmd_q == CMD_TARGET_ADDR);

  // nv commit: value lands after the programming delay
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      progCnt_q <= '0;
      pendCmd_q <= '0;
      pendData_q <= '0;
      emis_q <= EMISSIVITY_RESET;
      addrCell_q <= TARGET_ADDR_RESET;
    end else if (clkEn) begin
      if (stopSeen && writeValid && progCnt_q == '0) begin
        progCnt_q <= 24'(PROG_CYCLES);
        pendCmd_q <= cmd_q;
        // zeros erase; address cell keeps only the low byte
        pendData_q <= (cmd_q == CMD_TARGET_ADDR) ? {8'h00, dataLo_q}
                                                 : {dataHi_q, dataLo_q};
      end else if (progCnt_q != '0) begin
        progCnt_q <= progCnt_q - 24'h000001;
        if (progCnt_q == 24'h000001) begin
          if (pendCmd_q == CMD_EMISSIVITY) begin
            emis_q <= pendData_q;
          end else begin
            addrCell_q <= pendData_q;
          end
        end
      end
    end
  end

  assign nvBusy = (progCnt_q != '0);
  assign emissivityCoefficient = emis_q;
  assign busTargetAddress = addrCell_q;

  // open drain: only ever pulls low
  always_comb begin
    case (state_q)
      ST_RXACK: sdaTarget = 1'b1;
      ST_TX: sdaTarget = ~shift_q[7];
      default: sdaTarget = 1'b0;
    endcase
  end

  // sda moves a hold-off after scl falls; idle and ignore release it at once, even with scl high
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      holdCnt_q <= '0;
      sdaOe <= 1'b0;
    end else if (clkEn) begin
      if (sclFall) begin
        holdCnt_q <= 8'(SDA_HOLD_CYC);
      end else if (holdCnt_q != '0) begin
        holdCnt_q <= holdCnt_q - 8'h01;
      end
      if (state_q == ST_IDLE || state_q == ST_IGNORE) begin
        sdaOe <= 1'b0;
      end else if (!sclSync_q && holdCnt_q == 8'h01) begin
        sdaOe <= sdaTarget;
      end
    end
  end

  assign sdaOut = 1'b0;
endmodule
`default_nettype wire

// File: sim/sts_host.sv
// smbus host model: drives scl and pulls sda low through its enable
`timescale 1ns/1ps
`default_nettype none
module sts_host (
  output logic scl,
  output logic hostSdaOe,
  input wire logic sda
);
  // link scaled far above the 10..100 khz bus range to keep runs short
  localparam int T = 32;
  initial begin
    scl = 1'b1;
    hostSdaOe = 1'b0;
  end
  // sda moves 320 ns into the low phase, after the target's own hold-off
  task automatic bitx(input logic o, output logic i);
    #(10 * T) hostSdaOe = ~o;
    #(T) scl = 1'b1;
    i = sda;
    #(4 * T) scl = 1'b0;
  endtask
  task automatic xfer(input logic [7:0] o, input logic ao, output logic [7:0] i, output logic ai);
    for (int b = 7; b >= 0; b--) bitx(o[b], i[b]);
    bitx(ao, ai);
  endtask
  task automatic start();
    #(4 * T) hostSdaOe = 1'b1;
    #(4 * T) scl = 1'b0;
  endtask
  task automatic rstart();
    #(10 * T) hostSdaOe = 1'b0;
    #(T) scl = 1'b1;
    #(2 * T) hostSdaOe = 1'b1;
    #(2 * T) scl = 1'b0;
  endtask
  task automatic stop();
    #(10 * T) hostSdaOe = 1'b1;
    #(T) scl = 1'b1;
    #(2 * T) hostSdaOe = 1'b0;
    #(4 * T);
  endtask
  // scl parked on purpose, to provoke the target's bus timeouts
  task automatic park(input logic hi, input int ns);
    scl = hi;
    #(ns) scl = 1'b0;
  endtask
endmodule
`default_nettype wire

// File: sim/sts_target_chk.sv
// port assertions for the smbus thermometer target
`timescale 1ns/1ps
`default_nettype none
module sts_target_chk #(
  parameter int unsigned LOW_TIMEOUT_CYCLES = 2000,
  parameter int unsigned HIGH_TIMEOUT_CYCLES = 1000,
  parameter int unsigned PROG_CYCLES = 200
) (
  input wire logic sys_clk,
  input wire logic reset,
  input wire logic clkEn,
  input wire logic sclIn,
  input wire logic sdaIn,
  input wire logic sdaOut,
  input wire logic sdaOe,
  input wire logic [15:0] dieTemperatureReading,
  input wire logic sensorError,
  input wire logic [15:0] emissivityCoefficient,
  input wire logic [15:0] busTargetAddress,
  input wire logic nvBusy
);
  logic [15:0] lowCnt_q, highCnt_q, busyCnt_q;
  // saturating, so a parked line never wraps back into range
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) begin
      lowCnt_q <= 16'h0000;
      highCnt_q <= 16'h0000;
    end else begin
      lowCnt_q <= sclIn ? 16'h0000 : lowCnt_q + {15'h0000, lowCnt_q != 16'hFFFF};
      highCnt_q <= !sclIn ? 16'h0000 : highCnt_q + {15'h0000, highCnt_q != 16'hFFFF};
    end
  end
  always_ff @(posedge sys_clk or posedge reset) begin
    if (reset) busyCnt_q <= 16'h0000;
    else busyCnt_q <= nvBusy ? busyCnt_q + 16'h0001 : 16'h0000;
  end
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (reset);
  sda_open_drain_a: assert property (sdaOut == 1'b0)
    else $error("sda output not zero");
  oe_rise_low_a: assert property ($rose(sdaOe) |-> !sclIn)
    else $error("sda pulled while scl high");
  oe_hold_off_a: assert property (
    $changed(sdaOe) && !sclIn && lowCnt_q < 16'h012C |-> lowCnt_q >= 16'h0048 && lowCnt_q <= 16'h005A)
    else $error("sda change outside hold-off window");
  low_timeout_a: assert property (lowCnt_q > LOW_TIMEOUT_CYCLES + 16 |-> !sdaOe)
    else $error("sda held after scl low timeout");
  high_timeout_a: assert property (highCnt_q > HIGH_TIMEOUT_CYCLES + 16 |-> !sdaOe)
    else $error("sda held after scl high timeout");
  busy_length_a: assert property (
    $fell(nvBusy) |-> busyCnt_q >= PROG_CYCLES - 1 && busyCnt_q <= PROG_CYCLES + 1)
    else $error("commit time wrong");
  cell_commit_a: assert property (
    $changed(emissivityCoefficient) || $changed(busTargetAddress) |-> $fell(nvBusy))
    else $error("cell changed outside commit");
  addr_upper_zero_a: assert property (busTargetAddress[15:8] == 8'h00)
    else $error("address cell high byte not zero");
endmodule
bind sts_target sts_target_chk #(.LOW_TIMEOUT_CYCLES(LOW_TIMEOUT_CYCLES),
  .HIGH_TIMEOUT_CYCLES(HIGH_TIMEOUT_CYCLES), .PROG_CYCLES(PROG_CYCLES)) i_sts_target_chk (
  .sys_clk(sys_clk), .reset(reset), .clkEn(clkEn), .sclIn(sclIn), .sdaIn(sdaIn),
  .sdaOut(sdaOut), .sdaOe(sdaOe), .dieTemperatureReading(dieTemperatureReading),
  .sensorError(sensorError), .emissivityCoefficient(emissivityCoefficient),
  .busTargetAddress(busTargetAddress), .nvBusy(nvBusy));
`default_nettype wire

// File: sim/test_sts_target.sv
// self-checking bench for the smbus thermometer target
`timescale 1ns/1ps
`default_nettype none
module test_sts_target;
  import sts_pkg::*;
  logic sys_clk = 1'b0;
  logic reset = 1'b1;
  logic [15:0] dieT = 16'h0000;
  logic sErr = 1'b0;
  logic scl, hostOe, sdaOut, sdaOe, nvBusy, k, p, ak;
  logic [15:0] emis, tgtAddr, w, v;
  logic [7:0] wrAddr = 8'h74;
  wire logic sda;
  int err_total = 0;
  int compares = 0;
  int cyc = 0;
  // pull-up: the line reads high once every party lets go
  assign sda = !(hostOe || sdaOe);
  always #2 sys_clk = ~sys_clk;
  sts_host i_sts_host (.scl(scl), .hostSdaOe(hostOe), .sda(sda));
  sts_target #(.LOW_TIMEOUT_CYCLES(2000), .HIGH_TIMEOUT_CYCLES(1000), .PROG_CYCLES(200))
    i_sts_target (.sys_clk(sys_clk), .reset(reset), .clkEn(1'b1), .sclIn(scl), .sdaIn(sda),
    .sdaOut(sdaOut), .sdaOe(sdaOe), .dieTemperatureReading(dieT), .sensorError(sErr),
    .emissivityCoefficient(emis), .busTargetAddress(tgtAddr), .nvBusy(nvBusy));
  task summarize();
    if (err_total == 0 && compares > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask
  task check(input logic [15:0] seen, input logic [15:0] exp);
    compares++;
    if (seen !== exp) begin
      err_total++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  function automatic logic [7:0] crc(input logic [7:0] c, input logic [7:0] b);
    logic [7:0] r;
    r = c ^ b;
    repeat (8) r = {r[6:0], 1'b0} ^ (r[7] ? 8'h07 : 8'h00);
    return r;
  endfunction
  function automatic logic [15:0] amb(input logic [15:0] r, input logic e);
    logic [15:0] c;
    c = (r < AMBIENT_MIN) ? AMBIENT_MIN : (r > AMBIENT_MAX) ? AMBIENT_MAX : r;
    return {e, c[14:0]};
  endfunction
  task wr(input logic [6:0] a, input logic [7:0] cmd, input logic [15:0] d, input logic [7:0] bad);
    logic [7:0] q;
    logic [7:0] pec;
    pec = crc(crc(crc(crc(8'h00, {a, 1'b0}), cmd), d[7:0]), d[15:8]);
    i_sts_host.start();
    i_sts_host.xfer({a, 1'b0}, 1'b1, q, k);
    check({15'h0000, k}, 16'h0000);
    i_sts_host.xfer(cmd, 1'b1, q, k);
    i_sts_host.xfer(d[7:0], 1'b1, q, k);
    i_sts_host.xfer(d[15:8], 1'b1, q, k);
    i_sts_host.xfer(pec ^ bad, 1'b1, q, k);
    i_sts_host.stop();
    check({15'h0000, nvBusy}, {15'h0000, bad == 8'h00});
    for (int n = 0; n < 400 && nvBusy !== 1'b0; n++) @(posedge sys_clk);
  endtask
  task rd(input logic [6:0] a, input logic [7:0] cmd, output logic ack);
    logic [7:0] q;
    logic [7:0] pec;
    i_sts_host.start();
    i_sts_host.xfer({a, 1'b0}, 1'b1, q, ack);
    i_sts_host.xfer(cmd, 1'b1, q, k);
    i_sts_host.rstart();
    i_sts_host.xfer({a, 1'b1}, 1'b1, q, k);
    i_sts_host.xfer(8'hFF, 1'b0, w[7:0], k);
    i_sts_host.xfer(8'hFF, 1'b0, w[15:8], k);
    i_sts_host.xfer(8'hFF, 1'b1, pec, k);
    i_sts_host.stop();
    p = pec === crc(crc(crc(crc(crc(8'h00, {a, 1'b0}), cmd), {a, 1'b1}), w[7:0]), w[15:8]);
    ack = ~ack;
  endtask
  always @(posedge sys_clk) begin
    cyc <= cyc + 1;
    if (cyc == 90000) begin
      err_total++;
      summarize();
    end
  end
  initial begin
    void'($urandom(32'hA7449173));
    repeat (2) @(posedge sys_clk);
    reset <= 1'b0;
    repeat (4) @(posedge sys_clk);
    check(emis, 16'hF850);
    check(tgtAddr, 16'h003A);
    for (int n = 0; n < 3; n++) begin
      @(posedge sys_clk);
      dieT <= (n == 0) ? 16'h0000 : (n == 1) ? 16'hFFFF : 16'($urandom);
      sErr <= 1'($urandom);
      @(posedge sys_clk);
      rd(7'h3A, CMD_AMBIENT, ak);
      check(w, amb(dieT, sErr));
      check({15'h0000, p}, 16'h0001);
    end
    wr(7'h3A, CMD_EMISSIVITY, 16'h0000, 8'h00);
    check(emis, 16'h0000);
    v = 16'h1998 + 16'($urandom % 32'h0000E668);
    wr(7'h3A, CMD_EMISSIVITY, v, 8'h00);
    check(emis, v);
    wr(7'h3A, CMD_EMISSIVITY, ~v, 8'h01);
    check(emis, v);
    // second pass parks scl high instead of low
    for (int hi = 0; hi < 2; hi++) begin
      i_sts_host.start();
      for (int b = 7; b >= 0; b--) i_sts_host.bitx(wrAddr[b], k);
      #330;
      check({15'h0000, sdaOe}, 16'h0001);
      i_sts_host.park(hi[0], 10000);
      check({15'h0000, sdaOe}, 16'h0000);
      i_sts_host.stop();
    end
    wr(7'h3A, CMD_TARGET_ADDR, 16'h0000, 8'h00);
    check(tgtAddr, 16'h0000);
    // address cell is now zero; the general address is answered whatever the cell holds
    wr(7'h00, CMD_TARGET_ADDR, 16'h004C, 8'h00);
    check(tgtAddr, 16'h004C);
    rd(7'h3A, CMD_EMISSIVITY, ak);
    check({15'h0000, ak}, 16'h0000);
    rd(7'h4C, CMD_EMISSIVITY, ak);
    check({15'h0000, ak}, 16'h0001);
    check(w, v);
    summarize();
  end
endmodule
`default_nettype wire
